/* File: dah_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dah_defines.svh"

// Summary of operation
// - decrement instruction loads accumulator with addressed memory byte minus one.
// - decrement instruction never writes memory; only accumulator and zero flag change.
// - halt instruction stops instruction acceptance and switches the system clock off.
// - memory, accumulator, zero and carry flags keep their contents while entering and during halt.
// - halt instruction clears the watchdog counter and its prescaler.
// - halt sets power-down flag, clears watchdog time-out flag unless a time-out comes in the same cycle, touches no other flag.
module dah_core
	import dah_pkg::*;
#(
	parameter int DATA_W = `DAH_DATA_W,
	parameter int ADDR_W = `DAH_ADDR_W
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic instr_valid,
	input wire dah_op_t instr_op,
	input wire logic [ADDR_W-1:0] instr_addr,
	input wire logic wb_acc_en,
	input wire logic [DATA_W-1:0] wb_acc_data,
	input wire logic wb_mem_en,
	input wire logic [DATA_W-1:0] wb_mem_data,
	input wire logic wb_flag_en,
	input wire logic wb_zero,
	input wire logic wb_carry,
	input wire logic wake,
	input wire logic [ADDR_W-1:0] peek_addr,
	output logic instr_ready,
	output logic sys_clk_en,
	output logic [DATA_W-1:0] accumulator_reg,
	output logic zero_flag,
	output logic carry_flag,
	output logic powerdown_status_flag,
	output logic watchdog_timeout_flag,
	output logic [`DAH_WDT_CNT_W-1:0] watchdog_counter,
	output logic [`DAH_WDT_PRE_W-1:0] watchdog_prescaler,
	output logic [DATA_W-1:0] peek_data
);

	localparam int DEPTH = 1 << ADDR_W;

	logic [DATA_W-1:0] mem_reg [DEPTH];
	dah_state_t state_reg;
	dah_state_t state_next;
	logic ready_reg;
	logic ready_next;
	logic clk_en_reg;
	logic clk_en_next;
	logic [DATA_W-1:0] acc_reg;
	logic [DATA_W-1:0] acc_next;
	logic zero_reg;
	logic zero_next;
	logic carry_reg;
	logic carry_next;
	logic pdf_reg;
	logic pdf_next;
	logic to_reg;
	logic to_next;
	logic [DATA_W-1:0] peek_reg;
	logic [DATA_W-1:0] peek_next;
	logic mem_we;
	logic [DATA_W-1:0] dec_result;
	logic take;
	logic wdt_clear;
	logic wdt_timeout;
	logic [`DAH_WDT_CNT_W-1:0] wdt_count;
	logic [`DAH_WDT_PRE_W-1:0] wdt_pre;
	logic [`DAH_WDT_CNT_W-1:0] wdt_count_reg;
	logic [`DAH_WDT_PRE_W-1:0] wdt_pre_reg;

	assign take = instr_valid && ready_reg;
	assign dec_result = mem_reg[instr_addr] - DATA_W'(`DAH_DEC_STEP);

	dah_wdt #(
		.PRESCALE(`DAH_WDT_PRESCALE),
		.PRE_W(`DAH_WDT_PRE_W),
		.CNT_W(`DAH_WDT_CNT_W),
		.LIMIT(`DAH_WDT_LIMIT)
	) u_wdt (
		.clock(clock),
		.rst(rst),
		.clear(wdt_clear),
		.count(wdt_count),
		.prescale(wdt_pre),
		.timeout(wdt_timeout)
	);

	// control state
	always_comb begin
		state_next = state_reg;
		ready_next = ready_reg;
		clk_en_next = clk_en_reg;
		wdt_clear = 1'b0;
		unique case (state_reg)
			DAH_ST_RUN: begin
				if (take && instr_op == DAH_OP_HALT) begin
					state_next = DAH_ST_ENTER;
					ready_next = 1'b0;
					clk_en_next = 1'b0;
					wdt_clear = 1'b1;
				end
			end
			DAH_ST_ENTER: begin
				state_next = DAH_ST_HALTED;
			end
			DAH_ST_HALTED: begin
				// watchdog keeps running so its time-out can end the halt
				if (wake || wdt_timeout) begin
					state_next = DAH_ST_RUN;
					ready_next = 1'b1;
					clk_en_next = 1'b1;
				end
			end
			default: begin
				state_next = DAH_ST_RUN;
				ready_next = 1'b1;
				clk_en_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= DAH_ST_RUN;
			ready_reg <= 1'b1;
			clk_en_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			ready_reg <= ready_next;
			clk_en_reg <= clk_en_next;
		end
	end

	// accumulator and flags
	always_comb begin
		acc_next = acc_reg;
		zero_next = zero_reg;
		carry_next = carry_reg;
		pdf_next = pdf_reg;
		to_next = to_reg;
		if (take) begin
			unique case (instr_op)
				DAH_OP_DECREMENT_TO_ACC_INSTR: begin
					acc_next = dec_result;
					zero_next = (dec_result == '0);
				end
				DAH_OP_HALT: begin
					pdf_next = 1'b1;
					to_next = 1'b0;
				end
				DAH_OP_OTHER: begin
					if (wb_acc_en) begin
						acc_next = wb_acc_data;
					end
					if (wb_flag_en) begin
						zero_next = wb_zero;
						carry_next = wb_carry;
					end
				end
				DAH_OP_NOP: begin
				end
			endcase
		end
		// a time-out in the same cycle as the halt clear is kept
		if (wdt_timeout) begin
			to_next = 1'b1;
		end
	end

	// accumulator, zero and carry values hold across halt
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_reg <= `DAH_ACC_RST;
			zero_reg <= 1'b0;
			carry_reg <= 1'b0;
			pdf_reg <= 1'b0;
			to_reg <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			zero_reg <= zero_next;
			carry_reg <= carry_next;
			pdf_reg <= pdf_next;
			to_reg <= to_next;
		end
	end

	// data memory: only the general write-back path may store
	always_comb begin
		mem_we = take && instr_op == DAH_OP_OTHER && wb_mem_en;
		peek_next = mem_reg[peek_addr];
	end

	// memory has no reset: contents survive halt untouched
	always_ff @(posedge clock) begin
		if (mem_we) begin
			mem_reg[instr_addr] <= wb_mem_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			peek_reg <= `DAH_MEM_RST;
			wdt_count_reg <= '0;
			wdt_pre_reg <= '0;
		end else begin
			peek_reg <= peek_next;
			wdt_count_reg <= wdt_count;
			wdt_pre_reg <= wdt_pre;
		end
	end

	assign instr_ready = ready_reg;
	assign sys_clk_en = clk_en_reg;
	assign accumulator_reg = acc_reg;
	assign zero_flag = zero_reg;
	assign carry_flag = carry_reg;
	assign powerdown_status_flag = pdf_reg;
	assign watchdog_timeout_flag = to_reg;
	assign watchdog_counter = wdt_count_reg;
	assign watchdog_prescaler = wdt_pre_reg;
	assign peek_data = peek_reg;

endmodule : dah_core

`default_nettype wire

/* File: dah_core_sva.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dah_defines.svh"

module dah_core_sva
	import dah_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic instr_valid,
	input wire dah_op_t instr_op,
	input wire logic [ADDR_W-1:0] instr_addr,
	input wire logic wb_mem_en,
	input wire logic wake,
	input wire logic [ADDR_W-1:0] peek_addr,
	input wire logic instr_ready,
	input wire logic sys_clk_en,
	input wire logic [DATA_W-1:0] accumulator_reg,
	input wire logic zero_flag,
	input wire logic carry_flag,
	input wire logic powerdown_status_flag,
	input wire logic watchdog_timeout_flag,
	input wire logic [`DAH_WDT_CNT_W-1:0] watchdog_counter,
	input wire logic [`DAH_WDT_PRE_W-1:0] watchdog_prescaler,
	input wire logic [DATA_W-1:0] peek_data
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic decrement_to_acc_instr;
	logic halt;
	assign decrement_to_acc_instr = instr_valid && instr_ready && instr_op == DAH_OP_DECREMENT_TO_ACC_INSTR;
	assign halt = instr_valid && instr_ready && instr_op == DAH_OP_HALT;
	// peek_data is one edge stale, so only a quiet cycle before gives the operand
	decrement_to_acc_instr_acc_a: assert property (
		decrement_to_acc_instr && $stable(peek_addr) && peek_addr == instr_addr && !$past(wb_mem_en)
		|=> accumulator_reg == $past(peek_data) - 8'h01) else $error("decrement result wrong");
	decrement_to_acc_instr_mem_a: assert property (
		decrement_to_acc_instr ##1 $stable(peek_addr) |=> $stable(peek_data)) else $error("memory changed");
	decrement_to_acc_instr_flags_a: assert property (
		decrement_to_acc_instr |=> zero_flag == (accumulator_reg == 8'h00) && $stable(carry_flag))
		else $error("zero or carry wrong");
	halt_stop_a: assert property (
		halt |=> !instr_ready && !sys_clk_en) else $error("halt did not stop");
	halt_keep_a: assert property (
		halt || !instr_ready |=> $stable(accumulator_reg) && $stable(zero_flag)
		&& $stable(carry_flag)) else $error("registers altered in halt");
	halt_wdt_a: assert property (
		halt |=> ##1 watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00)
		else $error("watchdog not cleared");
	halt_flags_a: assert property (
		halt |=> powerdown_status_flag && !watchdog_timeout_flag) else $error("halt flags wrong");
	cover property (decrement_to_acc_instr);
	cover property (halt);
	cover property (!instr_ready && wake);
endmodule : dah_core_sva

bind dah_core dah_core_sva #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) dah_core_sva_i (.*);

`default_nettype wire

/* File: dah_defines.svh */
`ifndef DAH_DEFINES_SVH
`define DAH_DEFINES_SVH

// data path width and reset values
`define DAH_DATA_W 8
`define DAH_ADDR_W 8
`define DAH_ACC_RST 8'h00
`define DAH_MEM_RST 8'h00
`define DAH_DEC_STEP 8'h01

// watchdog timing: prescale in system clock cycles, limit in prescaler ticks
`define DAH_WDT_PRESCALE 256
`define DAH_WDT_PRE_W 8
`define DAH_WDT_CNT_W 8
`define DAH_WDT_LIMIT 8'hff

`endif

/* File: dah_pkg.sv */
package dah_pkg;

	typedef enum logic [1:0] {
		DAH_OP_NOP = 2'b00,
		DAH_OP_DECREMENT_TO_ACC_INSTR = 2'b01,
		DAH_OP_HALT = 2'b10,
		DAH_OP_OTHER = 2'b11
	} dah_op_t;

	// gray along run -> entering -> halted
	typedef enum logic [1:0] {
		DAH_ST_RUN = 2'b00,
		DAH_ST_ENTER = 2'b01,
		DAH_ST_HALTED = 2'b11
	} dah_state_t;

endpackage : dah_pkg

/* File: dah_wdt.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dah_defines.svh"

module dah_wdt #(
	parameter int PRESCALE = `DAH_WDT_PRESCALE,
	parameter int PRE_W = `DAH_WDT_PRE_W,
	parameter int CNT_W = `DAH_WDT_CNT_W,
	parameter logic [`DAH_WDT_CNT_W-1:0] LIMIT = `DAH_WDT_LIMIT
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clear,
	output logic [CNT_W-1:0] count,
	output logic [PRE_W-1:0] prescale,
	output logic timeout
);

	logic [PRE_W-1:0] pre_reg;
	logic [PRE_W-1:0] pre_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic tick;
	logic timeout_reg;
	logic timeout_next;

	always_comb begin
		tick = (pre_reg == PRE_W'(PRESCALE - 1));
		pre_next = tick ? '0 : pre_reg + 1'b1;
		cnt_next = cnt_reg;
		timeout_next = 1'b0;
		if (tick) begin
			if (cnt_reg == LIMIT) begin
				cnt_next = '0;
				timeout_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
		// clearing both stages restarts the full timeout period
		if (clear) begin
			pre_next = '0;
			cnt_next = '0;
			timeout_next = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pre_reg <= '0;
			cnt_reg <= '0;
			timeout_reg <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
			timeout_reg <= timeout_next;
		end
	end

	assign count = cnt_reg;
	assign prescale = pre_reg;
	assign timeout = timeout_reg;

endmodule : dah_wdt

`default_nettype wire

/* File: tb_dah_core.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_dah_core;
	import dah_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0;
	dah_op_t instr_op = DAH_OP_NOP;
	logic [7:0] instr_addr = 8'h00;
	logic wb_acc_en = 1'b0;
	logic [7:0] wb_acc_data = 8'h00;
	logic wake = 1'b0;
	logic [7:0] peek_addr = 8'h00;
	wire logic wb_mem_en = wb_acc_en;
	wire logic wb_flag_en = wb_acc_en;
	wire logic [7:0] wb_mem_data = wb_acc_data;
	// preload the zero flag opposite to what the next decrement must give
	wire logic wb_zero = (wb_acc_data != 8'h01);
	// carry follows operand bit 7 so a decrement touching it shows up
	wire logic wb_carry = wb_acc_data[7];
	logic instr_ready, sys_clk_en, zero_flag, carry_flag;
	logic powerdown_status_flag, watchdog_timeout_flag;
	logic [7:0] accumulator_reg, peek_data, watchdog_counter, watchdog_prescaler;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;

	dah_core dah_core_i (.*);

	initial begin
		forever #12.5 clock = ~clock;
	end

	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task conclude;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude

	// one falling edge to the next; valid stays up so back to back needs no re-toggle
	task automatic issue(input dah_op_t op, input logic [7:0] a, input logic [7:0] d);
		instr_valid = 1'b1;
		instr_op = op;
		instr_addr = a;
		wb_acc_data = d;
		wb_acc_en = (op == DAH_OP_OTHER);
		@(negedge clock);
	endtask : issue

	task automatic idle;
		instr_valid = 1'b0;
		wb_acc_en = 1'b0;
		@(negedge clock);
	endtask : idle

	task automatic t_decrement_to_acc_instr(input logic [7:0] a, input logic [7:0] v, input int gap);
		peek_addr = a;
		issue(DAH_OP_OTHER, a, v);
		repeat (gap) idle();
		issue(DAH_OP_DECREMENT_TO_ACC_INSTR, a, 8'h00);
		chk("acc", v - 8'h01, accumulator_reg);
		chk("zero", v == 8'h01, zero_flag);
		chk("carry", {7'h00, v[7]}, carry_flag);
		idle();
		chk("mem", v, peek_data);
	endtask : t_decrement_to_acc_instr

	task automatic t_halt;
		logic [7:0] acc;
		logic [7:0] mem;
		logic z;
		logic c;
		int n;
		// let the watchdog time out and count on, so every clear below is visible
		n = 0;
		while (watchdog_timeout_flag !== 1'b1 && n < 66000) begin
			@(negedge clock);
			n++;
		end
		chk("to_before", 8'h01, watchdog_timeout_flag);
		n = 0;
		while (watchdog_counter == 8'h00 && n < 300) begin
			@(negedge clock);
			n++;
		end
		chk("cnt_before", 8'h01, watchdog_counter);
		acc = accumulator_reg;
		mem = peek_data;
		z = zero_flag;
		c = carry_flag;
		issue(DAH_OP_HALT, 8'h00, 8'h00);
		chk("ready", 8'h00, instr_ready);
		chk("clk_en", 8'h00, sys_clk_en);
		chk("pdf", 8'h01, powerdown_status_flag);
		chk("to", 8'h00, watchdog_timeout_flag);
		chk("zero_kept", z, zero_flag);
		chk("carry_kept", c, carry_flag);
		// offered while halted: must be ignored
		issue(DAH_OP_OTHER, peek_addr, 8'h33);
		chk("wdt_cnt", 8'h00, watchdog_counter);
		chk("wdt_pre", 8'h00, watchdog_prescaler);
		issue(DAH_OP_DECREMENT_TO_ACC_INSTR, peek_addr, 8'h00);
		chk("acc_kept", acc, accumulator_reg);
		chk("mem_kept", mem, peek_data);
		// drop the offer first, or the held decrement is taken on wake
		instr_valid = 1'b0;
		wake = 1'b1;
		n = 0;
		while (instr_ready !== 1'b1 && n < 8) begin
			@(negedge clock);
			n++;
		end
		wake = 1'b0;
		chk("woke", 8'h01, instr_ready);
		@(negedge clock);
		chk("clk_on", 8'h01, sys_clk_en);
		chk("pdf_hold", 8'h01, powerdown_status_flag);
	endtask : t_halt

	initial begin
		repeat (3) @(negedge clock);
		rst = 1'b0;
		t_decrement_to_acc_instr(8'h10, 8'h01, 0);
		t_decrement_to_acc_instr(8'h20, 8'h00, 1);
		t_decrement_to_acc_instr(8'h30, 8'h80, 1);
		t_halt();
		conclude();
	end

	always @(posedge clock) begin
		cycles++;
		// one full watchdog period plus a small margin
		if (cycles == 68000) begin
			$display("ERROR cycles expected below %0d seen %0d", 68000, cycles);
			mismatches++;
			conclude();
		end
	end
endmodule : tb_dah_core

`default_nettype wire
